// ### hw/sslp_pkg.sv
// Purpose: Shared constants and types for the status and low-power block.
// Assumes: Byte-wide registers on a small index-addressed port.
// Notes: Index values and field spots not fixed elsewhere are local picks.
package sslp_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] IDX_IRQ_A = 4'h0;
    localparam logic [3:0] IDX_IRQ_B = 4'h1;
    localparam logic [3:0] IDX_IRQ_C = 4'h2;
    localparam logic [3:0] IDX_BRK_WAKE = 4'h3;
    localparam logic [3:0] IDX_RST_CAUSE = 4'h4;
    localparam logic [3:0] IDX_BRK_CTRL = 4'h5;
    localparam logic [3:0] IDX_OPTIONS = 4'h6;
    localparam int BIT_BREAK_ENDED_LOWPOWER_FLAG = 1;
    localparam int BIT_BREAK_CLEAR_ENABLE = 7;
    localparam int BIT_SHORT_RECOVERY_OPTION = 0;
    localparam int BIT_WDOG_DIS = 1;
    localparam int BIT_POR = 7;
    localparam int BIT_PIN = 6;
    localparam int BIT_WDOG = 5;
    localparam int BIT_BADOP = 4;
    localparam int BIT_BADADR = 3;
    localparam int BIT_MON = 2;
    localparam int BIT_LOWV = 1;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] POR_ONLY = 8'h80;
    localparam int REC_LONG = 4096;
    localparam int REC_SHORT = 32;
    localparam int CNT_W = 13;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_RECOVER
    } sslp_state_type;

    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic bad_op;
        logic bad_adr;
        logic lowv;
    } sslp_rst_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sslp_bus_type;
endpackage

// ### hw/sslp_core.sv
// Purpose: Interrupt status view, break handling, wait/stop sequencing
//          and reset cause capture for the system integration logic.
// Assumes: All inputs synchronous to i_clock; slow clock is a level input.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// [R1] Each pending flag reads 1 while its source requests, else 0.
// [R2] Unused bits of the three pending registers always read zero.
// [R3] All reset causes equal, above every interrupt, never arbitrated.
// [R4] Break request forces the core to the software interrupt vector.
// [R5] In break, flags clear only when break clear enable is 1.
// [R6] A flag cleared during break stays cleared after break ends.
// [R7] Two-step clears stay protected in break; second step after clears.
// [R8] Wait or stop instruction clears the core global interrupt mask.
// [R9] Wait gates core clock only; enabled interrupt stacks one cycle on.
// [R10] Reset or break ends wait and stop; break sets the wake flag.
// [R11] Watchdog disable option zero keeps watchdog running in wait.
// [R12] Stop resets recovery counter, stops clocks; irq, reset, break exit.
// [R13] Recovery is 4096 slow cycles, or 32 with short option set.
// [R14] Counter held in reset until recovery, then times recovery.
// [R15] Software should keep short recovery clear with a crystal.
// [R16] Wake flag reads 1 after break exit; cleared by zero write, reset.
// [R17] Reading the reset cause register clears all its flags.
// [R18] Power-on sets the power-on flag and clears the others.
// [R19] Pin, watchdog, bad opcode, bad fetch, low voltage: own flags.
// [R20] Monitor flag set when vector erased after power-on, irq high.
// [R21] Pending registers are read-only; writes change nothing.
`timescale 1ns/1ns
`default_nettype none
module sslp_core #(
    parameter int REC_LONG_CYC = sslp_pkg::REC_LONG,
    parameter int REC_SHORT_CYC = sslp_pkg::REC_SHORT
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire sslp_pkg::sslp_bus_type i_bus,
    output logic [7:0] o_rdata,
    input wire logic [15:1] i_irq_req,
    input wire logic i_wake_irq,
    input wire logic i_break_irq,
    input wire logic i_break_done,
    input wire logic i_wait_exec,
    input wire logic i_stop_exec,
    input wire logic i_slow_clk,
    input wire sslp_pkg::sslp_rst_type i_rst_req,
    input wire logic i_vector_erased,
    input wire logic i_irq_at_supply,
    output logic o_force_swi,
    output logic o_flag_clear_allow,
    output logic o_clear_imask,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_stack_start,
    output logic o_watchdog_run,
    output logic o_sys_reset
);
    sslp_pkg::sslp_state_type state_ff, nxt_state;
    logic [7:0] rdata_ff, rcause_ff, nxt_rcause;
    logic [7:0] stat_a, stat_b, stat_c, rd_mux;
    logic [1:0] opt_ff;
    logic [sslp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic break_ended_lowpower_flag_ff, break_clear_enable_ff, brk_ff, slow_prev_ff, por_dly_ff;
    logic swi_ff, allow_ff, imask_ff, cpu_en_ff, per_en_ff;
    logic stack_ff, wdog_ff, sysrst_ff, brk_wake_ff, nxt_brk_wake;
    logic tick, rst_any, in_low, brk_low, rec_done, go_low;
    logic wr_wake, wr_ctrl, wr_opt, rd_rc, mon_hit;
    logic [sslp_pkg::CNT_W-1:0] rec_last;

    // Pending flags follow their sources live; empty positions tie low.
    assign stat_a = {i_irq_req[6:3], 1'b0, i_irq_req[1], 2'b00}; // R1 R2
    assign stat_b = {i_irq_req[14:10], 1'b0, i_irq_req[8:7]}; // R1 R2
    assign stat_c = {7'h00, i_irq_req[15]}; // R1 R2

    // Pending registers have no write decode at all.
    assign wr_wake = i_bus.wr && i_bus.addr == sslp_pkg::IDX_BRK_WAKE; // R21
    assign wr_ctrl = i_bus.wr && i_bus.addr == sslp_pkg::IDX_BRK_CTRL;
    assign wr_opt = i_bus.wr && i_bus.addr == sslp_pkg::IDX_OPTIONS;
    assign rd_rc = i_bus.rd && i_bus.addr == sslp_pkg::IDX_RST_CAUSE;

    always_comb begin
        case (i_bus.addr)
            sslp_pkg::IDX_IRQ_A: rd_mux = stat_a;
            sslp_pkg::IDX_IRQ_B: rd_mux = stat_b;
            sslp_pkg::IDX_IRQ_C: rd_mux = stat_c;
            sslp_pkg::IDX_BRK_WAKE: rd_mux = 8'(break_ended_lowpower_flag_ff) << sslp_pkg::BIT_BREAK_ENDED_LOWPOWER_FLAG;
            sslp_pkg::IDX_RST_CAUSE: rd_mux = rcause_ff;
            sslp_pkg::IDX_BRK_CTRL: rd_mux = 8'(break_clear_enable_ff) << sslp_pkg::BIT_BREAK_CLEAR_ENABLE;
            sslp_pkg::IDX_OPTIONS: rd_mux = {6'h00, opt_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // Every cause is simply OR-ed; no cause waits behind another.
    assign rst_any = |i_rst_req; // R3
    assign tick = i_slow_clk && !slow_prev_ff;
    assign in_low = state_ff == sslp_pkg::ST_WAIT
        || state_ff == sslp_pkg::ST_STOP;
    assign brk_low = in_low && i_break_irq && !rst_any; // R10
    assign go_low = state_ff == sslp_pkg::ST_RUN && !rst_any;
    assign rec_last = opt_ff[sslp_pkg::BIT_SHORT_RECOVERY_OPTION]
        ? sslp_pkg::CNT_W'(REC_SHORT_CYC - 1)
        : sslp_pkg::CNT_W'(REC_LONG_CYC - 1); // R13
    assign rec_done = state_ff == sslp_pkg::ST_RECOVER && tick
        && cnt_ff == rec_last; // R13
    assign mon_hit = por_dly_ff && i_vector_erased && i_irq_at_supply;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_brk_wake = brk_wake_ff;
        case (state_ff)
            sslp_pkg::ST_RUN: begin
                if (i_stop_exec) begin
                    nxt_state = sslp_pkg::ST_STOP;
                end else if (i_wait_exec) begin
                    nxt_state = sslp_pkg::ST_WAIT;
                end
            end
            sslp_pkg::ST_WAIT: begin
                if (i_wake_irq || i_break_irq) begin
                    nxt_state = sslp_pkg::ST_RUN; // R9 R10
                end
            end
            sslp_pkg::ST_STOP: begin
                nxt_cnt = '0; // R14
                if (i_wake_irq || i_break_irq) begin
                    nxt_state = sslp_pkg::ST_RECOVER; // R12
                    nxt_brk_wake = i_break_irq;
                end
            end
            sslp_pkg::ST_RECOVER: begin
                if (rec_done) begin
                    nxt_state = sslp_pkg::ST_RUN;
                    nxt_cnt = '0;
                end else if (tick) begin
                    nxt_cnt = cnt_ff + 1'b1; // R14
                end
            end
            default: nxt_state = sslp_pkg::ST_RUN;
        endcase
        // Reset ends any low-power mode at once.
        if (rst_any) begin
            nxt_state = sslp_pkg::ST_RUN; // R3 R10 R12
            nxt_cnt = '0;
        end
    end

    // A new cause wins over a clearing read in the same cycle.
    always_comb begin
        nxt_rcause = rd_rc ? 8'h00 : rcause_ff; // R17
        if (rst_any) begin
            nxt_rcause = 8'h00;
            nxt_rcause[sslp_pkg::BIT_PIN] = i_rst_req.pin; // R19
            nxt_rcause[sslp_pkg::BIT_WDOG] = i_rst_req.wdog; // R19
            nxt_rcause[sslp_pkg::BIT_BADOP] = i_rst_req.bad_op; // R19
            nxt_rcause[sslp_pkg::BIT_BADADR] = i_rst_req.bad_adr; // R19
            nxt_rcause[sslp_pkg::BIT_LOWV] = i_rst_req.lowv; // R19
        end
        if (i_rst_req.por) begin
            nxt_rcause = sslp_pkg::POR_ONLY; // R18
        end
        if (mon_hit) begin
            nxt_rcause[sslp_pkg::BIT_MON] = 1'b1; // R20
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= sslp_pkg::ST_RUN;
            cnt_ff <= '0;
            brk_wake_ff <= 1'b0;
            rcause_ff <= sslp_pkg::RST_VAL;
            rdata_ff <= 8'h00;
            slow_prev_ff <= 1'b0;
            por_dly_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            brk_wake_ff <= nxt_brk_wake;
            rcause_ff <= nxt_rcause;
            rdata_ff <= i_bus.rd ? rd_mux : 8'h00;
            slow_prev_ff <= i_slow_clk;
            por_dly_ff <= i_rst_req.por;
        end
    end

    // Software-owned bits; the wake flag set beats a zero write.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            break_ended_lowpower_flag_ff <= 1'b0;
            break_clear_enable_ff <= 1'b0;
            opt_ff <= 2'b00;
        end else begin
            if (rst_any) begin
                break_ended_lowpower_flag_ff <= 1'b0; // R16
            end else if (brk_low) begin
                break_ended_lowpower_flag_ff <= 1'b1; // R10 R16
            end else if (wr_wake && !i_bus.wdata[sslp_pkg::BIT_BREAK_ENDED_LOWPOWER_FLAG]) begin
                break_ended_lowpower_flag_ff <= 1'b0; // R16
            end
            if (wr_ctrl) begin
                break_clear_enable_ff <= i_bus.wdata[sslp_pkg::BIT_BREAK_CLEAR_ENABLE];
            end
            if (wr_opt) begin
                opt_ff <= i_bus.wdata[1:0];
            end
        end
    end

    // Break state lasts until the core reports its handler return.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            brk_ff <= 1'b0;
            swi_ff <= 1'b0;
            allow_ff <= 1'b1;
        end else begin
            if (rst_any) begin
                brk_ff <= 1'b0;
            end else if (i_break_irq) begin
                brk_ff <= 1'b1;
            end else if (i_break_done) begin
                brk_ff <= 1'b0;
            end
            // Break forcing waits out stop recovery, then fires once.
            swi_ff <= !rst_any && ((i_break_irq
                && state_ff != sslp_pkg::ST_STOP)
                || (rec_done && brk_wake_ff)); // R3 R4
            // Peripherals clear only on this grant; what they clear stays
            // cleared, and a pending second step simply waits for it.
            allow_ff <= !brk_ff || break_clear_enable_ff; // R5 R6 R7
        end
    end

    // Clock gating and wake pulses.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            imask_ff <= 1'b0;
            cpu_en_ff <= 1'b1;
            per_en_ff <= 1'b1;
            stack_ff <= 1'b0;
            wdog_ff <= 1'b0;
            sysrst_ff <= 1'b0;
        end else begin
            imask_ff <= go_low && (i_wait_exec || i_stop_exec); // R8
            cpu_en_ff <= nxt_state == sslp_pkg::ST_RUN; // R9 R12
            per_en_ff <= nxt_state == sslp_pkg::ST_RUN
                || nxt_state == sslp_pkg::ST_WAIT; // R9 R12
            stack_ff <= !rst_any && ((state_ff == sslp_pkg::ST_WAIT
                && i_wake_irq && !i_break_irq)
                || (rec_done && !brk_wake_ff)); // R9 R13
            wdog_ff <= !opt_ff[sslp_pkg::BIT_WDOG_DIS]; // R11
            sysrst_ff <= rst_any; // R3
        end
    end

    assign o_rdata = rdata_ff;
    assign o_force_swi = swi_ff;
    assign o_flag_clear_allow = allow_ff;
    assign o_clear_imask = imask_ff;
    assign o_cpu_clk_en = cpu_en_ff;
    assign o_periph_clk_en = per_en_ff;
    assign o_stack_start = stack_ff;
    assign o_watchdog_run = wdog_ff;
    assign o_sys_reset = sysrst_ff;

    // Checks.
    wait_wake_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == sslp_pkg::ST_WAIT && i_wake_irq && !i_break_irq
        && !rst_any |=> o_stack_start && o_cpu_clk_en) // R9
        else $error("wait wake did not stack");
    imask_clr_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        go_low && i_stop_exec |=> o_clear_imask && !o_periph_clk_en) // R8 R12
        else $error("stop entry wrong");
    break_ended_lowpower_flag_set_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        brk_low |=> break_ended_lowpower_flag_ff) // R10 R16
        else $error("break wake flag not set");
    rc_read_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        rd_rc && !rst_any && !mon_hit |=> rcause_ff == 8'h00) // R17
        else $error("reset cause not cleared on read");
    por_flag_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_rst_req.por ##1 !mon_hit |-> rcause_ff == sslp_pkg::POR_ONLY) // R18
        else $error("power-on flags wrong");
    stop_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == sslp_pkg::ST_STOP |=> cnt_ff == '0) // R14
        else $error("counter ran in stop");
    rec_end_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        rec_done && !rst_any |=> state_ff == sslp_pkg::ST_RUN
        && (o_stack_start || o_force_swi)) // R13
        else $error("recovery end wrong");
    rec_min_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $rose(state_ff == sslp_pkg::ST_RECOVER) |->
        state_ff == sslp_pkg::ST_RECOVER [*8]) // R13
        else $error("recovery too short");
    brk_swi_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_break_irq && !rst_any && state_ff == sslp_pkg::ST_RUN
        |=> o_force_swi) // R4
        else $error("break did not force vector");
    protect_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        brk_ff && !break_clear_enable_ff |=> !o_flag_clear_allow) // R5
        else $error("flags clearable in break");
    unused_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_bus.rd && i_bus.addr == sslp_pkg::IDX_IRQ_C
        |=> o_rdata[7:1] == 7'h00) // R2
        else $error("unused bits set");
    rst_wins_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        rst_any |=> state_ff == sslp_pkg::ST_RUN && o_sys_reset) // R3
        else $error("reset did not win");
    wait_cov: cover property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == sslp_pkg::ST_WAIT ##1 o_stack_start);
    stop_cov: cover property (@(posedge i_clock) disable iff (!i_nrst)
        rec_done && !brk_wake_ff);
    brk_cov: cover property (@(posedge i_clock) disable iff (!i_nrst)
        brk_low && state_ff == sslp_pkg::ST_STOP);
    brk_wait_cov: cover property (@(posedge i_clock) disable iff (!i_nrst)
        brk_low && state_ff == sslp_pkg::ST_WAIT);
    rc_clr_cov: cover property (@(posedge i_clock) disable iff (!i_nrst)
        rd_rc && rcause_ff != 8'h00);

    // Status view, wake flag, break, watchdog, clock gating, reset cause and counter; reset is excluded where it may win.
    stat_a_a: assert property (@(posedge i_clock) // R2
        disable iff (!i_nrst) i_bus.rd && i_bus.addr == sslp_pkg::IDX_IRQ_A
        |=> o_rdata[3] == 1'b0 && o_rdata[1:0] == 2'b00)
        else $error("pending a spare bits set");
    stat_b_a: assert property (@(posedge i_clock) // R2
        disable iff (!i_nrst) i_bus.rd && i_bus.addr == sslp_pkg::IDX_IRQ_B
        |=> o_rdata[2] == 1'b0)
        else $error("pending b spare bit set");
    pend_live_a: assert property (@(posedge i_clock) // R1
        disable iff (!i_nrst) i_bus.rd && i_bus.addr == sslp_pkg::IDX_IRQ_C
        |=> o_rdata[0] == $past(i_irq_req[15]))
        else $error("pending flag does not follow source");
    wake_clr_a: assert property (@(posedge i_clock) // R16
        disable iff (!i_nrst) wr_wake && !i_bus.wdata[sslp_pkg::BIT_BREAK_ENDED_LOWPOWER_FLAG]
        && !brk_low && !rst_any |=> !break_ended_lowpower_flag_ff)
        else $error("wake flag not cleared by write");
    wake_rst_a: assert property (@(posedge i_clock) // R16
        disable iff (!i_nrst) rst_any
        |=> !break_ended_lowpower_flag_ff)
        else $error("wake flag survived reset");
    allow_on_a: assert property (@(posedge i_clock) // R5 R6
        disable iff (!i_nrst) !brk_ff
        |=> o_flag_clear_allow)
        else $error("flags locked outside break");
    swi_stop_a: assert property (@(posedge i_clock) // R4 R13
        disable iff (!i_nrst) i_break_irq && state_ff == sslp_pkg::ST_STOP
        |=> !o_force_swi)
        else $error("vector forced before recovery");
    wdog_run_a: assert property (@(posedge i_clock) // R11
        disable iff (!i_nrst) !opt_ff[sslp_pkg::BIT_WDOG_DIS]
        |=> o_watchdog_run)
        else $error("watchdog stopped");
    wait_clk_a: assert property (@(posedge i_clock) // R9
        disable iff (!i_nrst) state_ff == sslp_pkg::ST_WAIT
        |-> !o_cpu_clk_en && o_periph_clk_en)
        else $error("wait clock gating wrong");
    stop_clk_a: assert property (@(posedge i_clock) // R12
        disable iff (!i_nrst) state_ff == sslp_pkg::ST_STOP
        |-> !o_cpu_clk_en && !o_periph_clk_en)
        else $error("stop clock gating wrong");
    pin_flag_a: assert property (@(posedge i_clock) // R19
        disable iff (!i_nrst) i_rst_req.pin && !i_rst_req.por
        |=> rcause_ff[sslp_pkg::BIT_PIN])
        else $error("pin reset flag missing");
    imask_wait_a: assert property (@(posedge i_clock) // R8 R9
        disable iff (!i_nrst) go_low && i_wait_exec && !i_stop_exec
        |=> o_clear_imask && !o_cpu_clk_en)
        else $error("wait entry wrong");
    rec_cnt_a: assert property (@(posedge i_clock) // R14
        disable iff (!i_nrst) state_ff == sslp_pkg::ST_RECOVER && tick
        && !rec_done && !rst_any |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("recovery counter skipped");
endmodule
`default_nettype wire

// ### sim/sslp_far.sv
// Purpose: Stand-in for the core and peripherals around the block.
// Assumes: The slow clock runs free at one tenth of the bus clock.
// Notes: Break return comes only when the bench asks, so break can be held.
`timescale 1ns/1ns
`default_nettype none
module sslp_far (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [15:1] i_irq_req,
    input wire logic [15:1] i_irq_en,
    input wire logic i_force_swi,
    input wire logic i_ret,
    output logic o_slow_clk,
    output logic o_wake_irq,
    output logic o_break_done
);
    logic [2:0] div_ff;
    logic brk_ff;
    logic ret_ff;
    wire div_end = (div_ff == 3'h4);
    // Only enabled sources may wake the block.
    assign o_wake_irq = |(i_irq_req & i_irq_en);
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_ff <= 3'h0;
            o_slow_clk <= 1'h0;
            brk_ff <= 1'h0;
            ret_ff <= 1'h0;
            o_break_done <= 1'h0;
        end else begin
            div_ff <= div_end ? 3'h0 : div_ff + 3'h1;
            o_slow_clk <= div_end ? !o_slow_clk : o_slow_clk;
            ret_ff <= i_ret;
            o_break_done <= brk_ff & i_ret & !ret_ff;
            brk_ff <= i_force_swi | (brk_ff & !o_break_done);
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for the status and low-power block.
// Assumes: Recovery counts are shortened to keep the run brief.
// Notes: Read data are noted in a queue and compared by a watcher.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int REC_L = 40;
    localparam int REC_S = 8;
    logic i_clock = 1'h0;
    logic nrst = 1'h0;
    sslp_pkg::sslp_bus_type bus = '0;
    sslp_pkg::sslp_rst_type rq = '0;
    logic [15:1] irq = '0;
    logic [15:1] en = '0;
    logic [15:1] v;
    logic brk = 1'h0, wt = 1'h0, st = 1'h0, ret = 1'h0;
    logic ver = 1'h0, sup = 1'h0;
    logic [7:0] rdata;
    logic software_interrupt, allow, imask, cpu_en, per_en, stack, wdog, slow, wake, done;
    logic sysr;
    logic rd_seen = 1'h0;
    logic prev;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h0d89;
    int cnt;
    int r;
    int pos[6] = '{sslp_pkg::BIT_LOWV, sslp_pkg::BIT_BADADR,
        sslp_pkg::BIT_BADOP, sslp_pkg::BIT_WDOG, sslp_pkg::BIT_PIN,
        sslp_pkg::BIT_POR};

    always #10 i_clock = ~i_clock;

    sslp_core #(.REC_LONG_CYC(REC_L), .REC_SHORT_CYC(REC_S)) u_sslp_core (
        .i_clock(i_clock), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
        .i_irq_req(irq), .i_wake_irq(wake), .i_break_irq(brk),
        .i_break_done(done), .i_wait_exec(wt), .i_stop_exec(st),
        .i_slow_clk(slow), .i_rst_req(rq), .i_vector_erased(ver),
        .i_irq_at_supply(sup), .o_force_swi(software_interrupt), .o_flag_clear_allow(allow),
        .o_clear_imask(imask), .o_cpu_clk_en(cpu_en),
        .o_periph_clk_en(per_en), .o_stack_start(stack),
        .o_watchdog_run(wdog), .o_sys_reset(sysr));
    sslp_far u_sslp_far (
        .i_clock(i_clock), .i_nrst(nrst), .i_irq_req(irq), .i_irq_en(en),
        .i_force_swi(software_interrupt), .i_ret(ret), .o_slow_clk(slow),
        .o_wake_irq(wake), .o_break_done(done));

    task automatic chk(input string nm, input logic [7:0] seen,
            input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(posedge i_clock) begin
        if (rd_seen) begin
            chk("rdata", rdata, exp_q.pop_front());
        end
        rd_seen <= bus.rd;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'h1;
        @(posedge i_clock);
        bus.wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        bus.addr <= a;
        bus.rd <= 1'h1;
        exp_q.push_back(e);
        @(posedge i_clock);
        bus.rd <= 1'h0;
    endtask

    // Pulse order is return, stop, wait, break.
    task automatic pulse(input logic [3:0] m);
        @(posedge i_clock);
        {ret, st, wt, brk} <= m;
        @(posedge i_clock);
        {ret, st, wt, brk} <= 4'h0;
        #1;
    endtask

    task automatic cause(input sslp_pkg::sslp_rst_type c);
        @(posedge i_clock);
        rq <= c;
        @(posedge i_clock);
        rq <= '0;
        #1;
        chk("sys_reset", sysr, 1'h1);
        repeat (3) @(posedge i_clock);
    endtask

    task automatic set_irq(input logic [15:1] x);
        @(posedge i_clock);
        irq <= x;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under five thousand cycles.
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end

    initial begin
        repeat (8) @(posedge i_clock);
        nrst <= 1'h1;
        rd(sslp_pkg::IDX_RST_CAUSE, sslp_pkg::RST_VAL);
        for (int i = 0; i < 6; i++) begin
            cause(sslp_pkg::sslp_rst_type'(6'h01 << i));
            rd(sslp_pkg::IDX_RST_CAUSE, 8'h01 << pos[i]);
            rd(sslp_pkg::IDX_RST_CAUSE, 8'h00);
        end
        cause(sslp_pkg::sslp_rst_type'(6'h18));
        rd(sslp_pkg::IDX_RST_CAUSE, 8'h60);
        ver <= 1'h1;
        sup <= 1'h1;
        cause(sslp_pkg::sslp_rst_type'(6'h20));
        rd(sslp_pkg::IDX_RST_CAUSE, 8'h84);
        ver <= 1'h0;
        sup <= 1'h0;
        repeat (4) begin
            v = 15'($random(seed));
            set_irq(v);
            rd(sslp_pkg::IDX_IRQ_A, {v[6:3], 1'h0, v[1], 2'h0});
            rd(sslp_pkg::IDX_IRQ_B, {v[14:10], 1'h0, v[8:7]});
            rd(sslp_pkg::IDX_IRQ_C, {7'h00, v[15]});
        end
        wr(sslp_pkg::IDX_IRQ_A, 8'hff);
        wr(sslp_pkg::IDX_IRQ_C, 8'hff);
        rd(sslp_pkg::IDX_IRQ_A, {v[6:3], 1'h0, v[1], 2'h0});
        rd(sslp_pkg::IDX_IRQ_C, {7'h00, v[15]});
        rd(4'hf, 8'h00);
        set_irq('0);
        en <= '1;
        pulse(4'h2);
        chk("imask", imask, 1'h1);
        chk("cpu_en", cpu_en, 1'h0);
        chk("per_en", per_en, 1'h1);
        chk("wdog", wdog, 1'h1);
        set_irq(15'h0004);
        tick(1);
        chk("stack", stack, 1'h1);
        chk("cpu_en", cpu_en, 1'h1);
        set_irq('0);
        wr(sslp_pkg::IDX_OPTIONS, 8'h02);
        pulse(4'h2);
        chk("wdog", wdog, 1'h0);
        pulse(4'h1);
        chk("swi", software_interrupt, 1'h1);
        rd(sslp_pkg::IDX_BRK_WAKE, 8'h02);
        chk("allow", allow, 1'h0);
        wr(sslp_pkg::IDX_BRK_CTRL, 8'h80);
        tick(2);
        chk("allow", allow, 1'h1);
        wr(sslp_pkg::IDX_BRK_CTRL, 8'h00);
        rd(sslp_pkg::IDX_BRK_CTRL, 8'h00);
        tick(2);
        chk("allow", allow, 1'h0);
        pulse(4'h8);
        tick(3);
        chk("allow", allow, 1'h1);
        wr(sslp_pkg::IDX_BRK_WAKE, 8'h02);
        rd(sslp_pkg::IDX_BRK_WAKE, 8'h02);
        wr(sslp_pkg::IDX_BRK_WAKE, 8'h00);
        rd(sslp_pkg::IDX_BRK_WAKE, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(sslp_pkg::IDX_OPTIONS, 8'(s));
            r = s ? REC_S : REC_L;
            pulse(4'h4);
            chk("per_en", per_en, 1'h0);
            chk("imask", imask, 1'h1);
            set_irq(15'h4000);
            cnt = 0;
            prev = slow;
            for (int k = 0; k < 1000 && stack !== 1'h1; k++) begin
                @(posedge i_clock);
                cnt += int'(slow & !prev);
                prev = slow;
            end
            chk("recovery", 1'(cnt >= r && cnt <= r + 2), 1'h1);
            tick(1);
            chk("per_en", per_en, 1'h1);
            set_irq('0);
        end
        pulse(4'h4);
        cause(sslp_pkg::sslp_rst_type'(6'h10));
        chk("per_en", per_en, 1'h1);
        rd(sslp_pkg::IDX_RST_CAUSE, 8'h40);
        tick(3);
        complete_run;
    end
endmodule
`default_nettype wire
